// [design/lcc_pkg.sv]
// Constants, register map and helpers for the logic cluster control generator.
package lcc_pkg;
    localparam int NUM_CELLS = 10;
    localparam int ROW_CLOCKS = 8;
    localparam int ROW_SEL_W = 3;
    localparam int ROUTE_LINES = 16;
    localparam int LOCAL_W = ROUTE_LINES + 3 * NUM_CELLS;
    localparam int SEL_W = 6;
    localparam int FIELD_STRIDE = 8;
    localparam int CELL_IN_W = 4;
    localparam int LUT_W = 16;
    localparam logic [SEL_W-1:0] SEL_ONE = 6'h3f;
    localparam logic [SEL_W-1:0] SEL_ZERO = 6'h3e;

    localparam logic [7:0] OFF_CLK_CFG = 8'h00;
    localparam logic [7:0] OFF_SRC_SEL0 = 8'h04;
    localparam logic [7:0] OFF_SRC_SEL1 = 8'h08;
    localparam logic [7:0] OFF_CELL_CLK = 8'h0c;
    localparam logic [7:0] OFF_CHAIN = 8'h10;
    localparam logic [7:0] OFF_LUT_MASK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    localparam int CLK_A_SEL_LSB = 0;
    localparam int CLK_A_FALL = 3;
    localparam int CLK_B_SEL_LSB = 4;
    localparam int CLK_B_FALL = 7;
    localparam int ARITH_BIT = 8;
    localparam int REGCH_LSB = 0;
    localparam int CASC_LSB = 16;
    localparam int STAT_GATE_LSB = 16;
    localparam int STAT_CLK_LSB = 18;

    // Field index inside the two source select words.
    localparam int F_ENA_A = 0;
    localparam int F_ENA_B = 1;
    localparam int F_ACLR_A = 2;
    localparam int F_ACLR_B = 3;
    localparam int F_SCLR = 0;
    localparam int F_SLOAD = 1;
    localparam int F_ALOAD = 2;
    localparam int F_ADDNSUB = 3;

    localparam logic [31:0] RST_CLK_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_SRC_SEL0 = 32'h3e3e_3f3f;
    localparam logic [31:0] RST_SRC_SEL1 = 32'h3e3e_3e3e;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [LUT_W-1:0] RST_LUT_MASK = 16'h0000;

    function automatic logic [SEL_W-1:0] field(input logic [31:0] word, input int k);
        field = word[k*FIELD_STRIDE +: SEL_W];
    endfunction

    function automatic logic pick(input logic [LOCAL_W-1:0] lines, input logic [SEL_W-1:0] sel);
        if (sel == SEL_ONE)
            pick = 1'b1;
        else if (int'(sel) < LOCAL_W)
            pick = lines[sel];
        else
            pick = 1'b0;
    endfunction
endpackage

// [design/lcc_cell.sv]
// One logic cell: LUT or one-bit add/subtract, chains and its register.
`timescale 1ns/1ps
module lcc_cell
    import lcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [lcc_pkg::CELL_IN_W-1:0] data,
    input wire logic [lcc_pkg::LUT_W-1:0] lut_mask,
    input wire logic arith,
    input wire logic addnsub,
    input wire logic cin,
    output logic cout,
    input wire logic casc_en,
    input wire logic lut_chain_in,
    output logic lut_out,
    input wire logic reg_chain_en,
    input wire logic reg_chain_in,
    input wire logic tick,
    input wire logic sclr,
    input wire logic sload,
    input wire logic aclr,
    input wire logic aload,
    output logic q
);
    typedef struct packed {
        logic q;
    } lcc_cell_s;

    lcc_cell_s st;
    lcc_cell_s next_st;
    logic op_a;
    logic [3:0] lut_idx;

    always_comb
    begin
        op_a = data[0] ^ addnsub;
        lut_idx = {data[3:1], casc_en ? lut_chain_in : data[0]};
        cout = (op_a & data[1]) | (cin & (op_a ^ data[1]));
        lut_out = arith ? (op_a ^ data[1] ^ cin) : lut_mask[lut_idx];
        next_st = st;
        // Async controls are applied in the pclk domain, ahead of any cluster clock tick.
        if (aclr)
            next_st.q = 1'b0;
        else if (aload)
            next_st.q = data[3];
        else if (tick)
        begin
            if (sclr)
                next_st.q = 1'b0;
            else if (sload)
                next_st.q = data[3];
            else
                next_st.q = reg_chain_en ? reg_chain_in : lut_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign q = st.q;

    a_aload_data: assert property (@(posedge pclk) disable iff (!presetn)
        aload && !aclr |=> q == $past(data[3])) else $error("async load did not take fourth input");
    a_preset_high: assert property (@(posedge pclk) disable iff (!presetn)
        aload && !aclr && data[3] ##1 !aclr |-> q) else $error("preset did not set register");
    a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
        tick && sclr && !aclr && !aload |=> !q) else $error("sync clear missed");
    a_reg_chain: assert property (@(posedge pclk) disable iff (!presetn)
        tick && reg_chain_en && !sclr && !sload && !aclr && !aload |=> q == $past(reg_chain_in))
        else $error("register chain value lost");
endmodule // lcc_cell

// [design/lcc_cluster.sv]
// Logic cluster control generator with APB registers and ten logic cells.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module lcc_cluster
    import lcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [lcc_pkg::ROW_CLOCKS-1:0] row_clock,
    input wire logic [lcc_pkg::ROUTE_LINES-1:0] routing_in,
    input wire logic [lcc_pkg::NUM_CELLS-1:0] left_link,
    input wire logic [lcc_pkg::NUM_CELLS-1:0] right_link,
    input wire logic [lcc_pkg::NUM_CELLS*lcc_pkg::CELL_IN_W-1:0] cell_data,
    input wire logic reg_chain_in,
    output logic [lcc_pkg::NUM_CELLS-1:0] cell_q,
    output logic cluster_clock_a,
    output logic cluster_clock_b
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [31:0] clk_cfg;
        logic [31:0] src0;
        logic [31:0] src1;
        logic [31:0] cell_clk;
        logic [31:0] chain;
        logic [LUT_W-1:0] lut_mask;
        logic [1:0] lvl_q;
        logic [1:0] gate_en;
        logic [1:0] clk_out;
    } lcc_state_s;

    lcc_state_s st;
    lcc_state_s next_st;
    logic [LOCAL_W-1:0] local_lines;
    logic [1:0] lvl;
    logic [1:0] ena;
    logic [1:0] aclr_ab;
    logic tick_a;
    logic tick_b;
    logic sclr;
    logic sload;
    logic aload;
    logic addnsub;
    logic arith;
    logic [31:0] rd_word;
    logic rd_hit;
    logic setup;
    logic wr_take;
    logic [NUM_CELLS:0] carry;
    logic [NUM_CELLS:0] lut_chain;
    logic [NUM_CELLS:0] reg_chain;
    logic [NUM_CELLS-1:0] lut_out;
    logic [NUM_CELLS-1:0] cell_tick;
    logic [NUM_CELLS-1:0] cell_aclr;

    // Own cell outputs feed back into the local lines; the same outputs leave as direct links.
    assign local_lines = {right_link, left_link, cell_q, routing_in};

    always_comb
    begin
        lvl[0] = row_clock[st.clk_cfg[CLK_A_SEL_LSB +: ROW_SEL_W]] ^ st.clk_cfg[CLK_A_FALL];
        lvl[1] = row_clock[st.clk_cfg[CLK_B_SEL_LSB +: ROW_SEL_W]] ^ st.clk_cfg[CLK_B_FALL];
        ena[0] = pick(local_lines, field(st.src0, F_ENA_A));
        ena[1] = pick(local_lines, field(st.src0, F_ENA_B));
        aclr_ab[0] = pick(local_lines, field(st.src0, F_ACLR_A));
        aclr_ab[1] = pick(local_lines, field(st.src0, F_ACLR_B));
        sclr = pick(local_lines, field(st.src1, F_SCLR));
        sload = pick(local_lines, field(st.src1, F_SLOAD));
        aload = pick(local_lines, field(st.src1, F_ALOAD));
        addnsub = pick(local_lines, field(st.src1, F_ADDNSUB));
        arith = st.clk_cfg[ARITH_BIT];
        // A cluster clock edge is the rising edge of its level, passed only when the enable is held.
        tick_a = lvl[0] & ~st.lvl_q[0] & st.gate_en[0];
        tick_b = lvl[1] & ~st.lvl_q[1] & st.gate_en[1];
    end

    always_comb
    begin
        rd_hit = 1'b1;
        case (paddr)
            OFF_CLK_CFG: rd_word = st.clk_cfg;
            OFF_SRC_SEL0: rd_word = st.src0;
            OFF_SRC_SEL1: rd_word = st.src1;
            OFF_CELL_CLK: rd_word = st.cell_clk;
            OFF_CHAIN: rd_word = st.chain;
            OFF_LUT_MASK: rd_word = {{(32-LUT_W){1'b0}}, st.lut_mask};
            OFF_STATUS:
            begin
                rd_word = RST_ZERO;
                rd_word[NUM_CELLS-1:0] = cell_q;
                rd_word[STAT_GATE_LSB +: 2] = st.gate_en;
                rd_word[STAT_CLK_LSB +: 2] = st.clk_out;
            end
            default:
            begin
                rd_word = RST_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign setup = psel & ~penable;
    assign wr_take = psel & penable & st.pready & pwrite;

    always_comb
    begin
        next_st = st;
        // Zero wait states: pready rises in the first access cycle of every transfer.
        next_st.pready = setup;
        next_st.pslverr = setup & ~rd_hit;
        if (setup && !pwrite)
            next_st.prdata = rd_word;
        if (wr_take)
        begin
            case (paddr)
                OFF_CLK_CFG: next_st.clk_cfg = pwdata;
                OFF_SRC_SEL0: next_st.src0 = pwdata;
                OFF_SRC_SEL1: next_st.src1 = pwdata;
                OFF_CELL_CLK: next_st.cell_clk = pwdata;
                OFF_CHAIN: next_st.chain = pwdata;
                OFF_LUT_MASK: next_st.lut_mask = pwdata[LUT_W-1:0];
                default: next_st.clk_out = st.clk_out;
            endcase
        end
        next_st.lvl_q = lvl;
        for (int c = 0; c < 2; c++)
        begin
            // Sampling only while the level is low keeps the gated clock free of runt pulses.
            if (!lvl[c])
                next_st.gate_en[c] = ena[c];
            next_st.clk_out[c] = lvl[c] & next_st.gate_en[c];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.clk_cfg <= RST_CLK_CFG;
            st.src0 <= RST_SRC_SEL0;
            st.src1 <= RST_SRC_SEL1;
            st.cell_clk <= RST_ZERO;
            st.chain <= RST_ZERO;
            st.lut_mask <= RST_LUT_MASK;
        end
        else
            st <= next_st;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign cluster_clock_a = st.clk_out[0];
    assign cluster_clock_b = st.clk_out[1];

    assign carry[0] = arith & addnsub;
    assign lut_chain[0] = 1'b0;
    assign reg_chain[0] = reg_chain_in;

    // Every cell sees the same sclr, sload, aload and addnsub; cell_clk picks clock A or B and its aclr for each cell.
    generate
        for (genvar i = 0; i < NUM_CELLS; i++)
        begin : g_cell
            assign cell_tick[i] = st.cell_clk[i] ? tick_b : tick_a;
            assign cell_aclr[i] = st.cell_clk[i] ? aclr_ab[1] : aclr_ab[0];
            assign lut_chain[i+1] = lut_out[i];
            assign reg_chain[i+1] = cell_q[i];
            lcc_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .data(cell_data[i*CELL_IN_W +: CELL_IN_W]),
                .lut_mask(st.lut_mask),
                .arith(arith),
                .addnsub(addnsub),
                .cin(carry[i]),
                .cout(carry[i+1]),
                .casc_en(st.chain[CASC_LSB+i]),
                .lut_chain_in(lut_chain[i]),
                .lut_out(lut_out[i]),
                .reg_chain_en(st.chain[REGCH_LSB+i]),
                .reg_chain_in(reg_chain[i]),
                .tick(cell_tick[i]),
                .sclr(sclr),
                .sload(sload),
                .aclr(cell_aclr[i]),
                .aload(aload),
                .q(cell_q[i])
            );
        end
    endgenerate

    a_gate_stable: assert property (@(posedge pclk) disable iff (!presetn)
        lvl[0] && st.lvl_q[0] |=> $stable(st.gate_en[0])) else $error("enable changed while clock high");
    a_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !st.gate_en[0] |-> !tick_a) else $error("clock edge passed a closed enable");
    a_clock_pair: assert property (@(posedge pclk) disable iff (!presetn)
        tick_b && !tick_a && !st.cell_clk[0] && !cell_aclr[0] && !aload |=> $stable(cell_q[0]))
        else $error("cell moved on the unpaired clock");
    a_sub_seed: assert property (@(posedge pclk) disable iff (!presetn)
        arith && addnsub && cell_data[0] == cell_data[1] |-> !lut_out[0])
        else $error("subtract of equal operands not zero");
    a_fall_edge: assert property (@(posedge pclk) disable iff (!presetn)
        tick_a && st.clk_cfg[CLK_A_FALL] && $stable(st.clk_cfg)
        |-> !row_clock[st.clk_cfg[CLK_A_SEL_LSB +: ROW_SEL_W]]) else $error("falling clock ticked on rise");
    a_lut_casc: assert property (@(posedge pclk) disable iff (!presetn)
        !arith && st.chain[CASC_LSB+1] |-> lut_out[1] == st.lut_mask[{cell_data[7:5], lut_out[0]}])
        else $error("LUT chain not cascaded");
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take && paddr == OFF_LUT_MASK |=> st.lut_mask == $past(pwdata[LUT_W-1:0]))
        else $error("LUT mask write lost");
    a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready || setup) else $error("pready timing wrong");

    c_shift: cover property (@(posedge pclk) disable iff (!presetn) tick_a && st.chain[REGCH_LSB+1]);
    c_subtract: cover property (@(posedge pclk) disable iff (!presetn) arith && addnsub && tick_a);
    c_both_clocks: cover property (@(posedge pclk) disable iff (!presetn) tick_a ##[1:20] tick_b);
    c_gated: cover property (@(posedge pclk) disable iff (!presetn) st.gate_en[0] ##1 !st.gate_en[0]);
endmodule // lcc_cluster

// [verif/lcc_fabric.sv]
// Row clock source standing in for the fabric outside the cluster.
`timescale 1ns/1ps
module lcc_fabric
(
    input wire logic pclk,
    input wire logic presetn,
    output logic [7:0] row_clock
);
    logic [1:0] cnt;
    // Four pclk cycles per phase leave margin over the two-cycle minimum the cluster samples.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 2'h0;
            row_clock <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3)
                row_clock <= ~row_clock;
        end
    end
endmodule // lcc_fabric

// [verif/test_lcc_cluster.sv]
// Self-checking bench for the logic cluster control generator.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_lcc_cluster;
    import lcc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] row_clock;
    logic [15:0] routing_in = 16'h0;
    logic [9:0] left_link = 10'h0;
    logic [9:0] right_link = 10'h0;
    logic [39:0] cell_data = 40'h0;
    logic reg_chain_in = 1'b0;
    logic [9:0] cell_q;
    logic cluster_clock_a;
    logic cluster_clock_b;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    lcc_fabric lcc_fabric_i (.pclk(pclk), .presetn(presetn), .row_clock(row_clock));
    lcc_cluster lcc_cluster_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .row_clock(row_clock), .routing_in(routing_in), .left_link(left_link), .right_link(right_link),
        .cell_data(cell_data), .reg_chain_in(reg_chain_in), .cell_q(cell_q),
        .cluster_clock_a(cluster_clock_a), .cluster_clock_b(cluster_clock_b));
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The slave sets the pace; only the run's cycle ceiling ends a hung transfer.
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    // Waits for the next rising cluster clock A; the cell registers show the new value by then.
    task automatic tick_a();
        int k;
        k = 0;
        // Skipping the current edge keeps a tick that races a register write from being taken.
        @(posedge pclk);
        while (cluster_clock_a !== 1'b0 && k < 40)
        begin
            @(posedge pclk);
            k++;
        end
        while (cluster_clock_a !== 1'b1 && k < 80)
        begin
            @(posedge pclk);
            k++;
        end
        #1;
        `CHK("tick wait", 1'b1, k < 80)
    endtask
    task automatic t_regs();
        logic [7:0] offs [6] = '{OFF_CLK_CFG, OFF_SRC_SEL0, OFF_SRC_SEL1, OFF_CELL_CLK, OFF_CHAIN, OFF_LUT_MASK};
        logic [31:0] rv [6] = '{RST_CLK_CFG, RST_SRC_SEL0, RST_SRC_SEL1, RST_ZERO, RST_ZERO, RST_ZERO};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 6; i++)
        begin
            apb(offs[i], 1'b0, 32'h0, r, e);
            `CHK("reset value", rv[i], r)
        end
        apb(8'h1c, 1'b0, 32'h0, r, e);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
    endtask
    task automatic t_sync();
        cell_data <= 40'h80_8800_8088;
        wr(OFF_SRC_SEL1, 32'h3e3e_3f3e);
        tick_a();
        `CHK("sync load", 10'h2cb, cell_q)
        wr(OFF_SRC_SEL1, 32'h3e3e_3e3f);
        tick_a();
        `CHK("sync clear", 10'h000, cell_q)
    endtask
    task automatic t_gate();
        logic seen;
        logic [31:0] r;
        logic e;
        wr(OFF_SRC_SEL0, 32'h3e3e_3f00);
        wr(OFF_SRC_SEL1, 32'h3e3e_3f3e);
        // The enable only closes once the level is low, so let the running high phase end first.
        repeat (8) @(posedge pclk);
        seen = 1'b0;
        repeat (24)
        begin
            @(posedge pclk);
            seen = seen | cluster_clock_a;
        end
        `CHK("gated clock", 1'b0, seen)
        `CHK("gated hold", 10'h000, cell_q)
        routing_in <= 16'h0001;
        tick_a();
        `CHK("routing enable", 10'h2cb, cell_q)
        apb(OFF_STATUS, 1'b0, 32'h0, r, e);
        `CHK("status", 11'h6cb, {r[16], r[9:0]})
    endtask
    task automatic t_async();
        wr(OFF_SRC_SEL0, 32'h3e3e_3e3e);
        wr(OFF_SRC_SEL1, 32'h3e1a_3e3e);
        cell_data <= {10{4'h8}};
        left_link <= 10'h001;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("async preset", 10'h3ff, cell_q)
        wr(OFF_SRC_SEL0, 32'h3e24_3e3e);
        right_link <= 10'h001;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("async clear", 10'h000, cell_q)
        left_link <= 10'h000;
        right_link <= 10'h000;
    endtask
    task automatic t_pair();
        wr(OFF_CELL_CLK, 32'h0000_000f);
        wr(OFF_SRC_SEL0, 32'h3e3e_3e3f);
        wr(OFF_SRC_SEL1, 32'h3e3e_3f3e);
        tick_a();
        `CHK("pair select", 10'h3f0, cell_q)
    endtask
    task automatic t_edge();
        logic bad;
        wr(OFF_CELL_CLK, 32'h0);
        wr(OFF_SRC_SEL0, 32'h3e3e_3f3f);
        wr(OFF_CLK_CFG, 32'h0000_0008);
        repeat (16) @(posedge pclk);
        bad = 1'b0;
        repeat (16)
        begin
            @(posedge pclk);
            bad = bad | (cluster_clock_b !== ~cluster_clock_a);
        end
        `CHK("both edges", 1'b0, bad)
    endtask
    task automatic t_chain();
        wr(OFF_SRC_SEL1, 32'h3e3e_3e3f);
        wr(OFF_CHAIN, 32'h0000_03ff);
        tick_a();
        wr(OFF_SRC_SEL1, 32'h3e3e_3e3e);
        reg_chain_in <= 1'b1;
        tick_a();
        `CHK("chain first", 10'h001, cell_q)
        tick_a();
        `CHK("chain second", 10'h003, cell_q)
    endtask
    task automatic t_arith();
        logic [9:0] a;
        logic [9:0] b;
        a = 10'h2a5;
        b = 10'h0f3;
        wr(OFF_CHAIN, 32'h0);
        wr(OFF_CLK_CFG, 32'h0000_0100);
        for (int i = 0; i < 10; i++)
            cell_data[4*i +: 4] <= {2'b00, b[i], a[i]};
        for (int m = 0; m < 2; m++)
        begin
            wr(OFF_SRC_SEL1, m ? 32'h3f3e_3e3e : 32'h3e3e_3e3e);
            tick_a();
            `CHK("add or subtract", m ? 10'(b - a) : 10'(a + b), cell_q)
        end
    endtask
    task automatic t_lut();
        logic [31:0] r;
        logic e;
        wr(OFF_CLK_CFG, 32'h0);
        wr(OFF_CHAIN, 32'h03fe_0000);
        cell_data <= 40'hee_eeee_eeef;
        wr(OFF_LUT_MASK, 32'h1234_8001);
        apb(OFF_LUT_MASK, 1'b0, 32'h0, r, e);
        `CHK("mask readback", 32'h0000_8001, r)
        tick_a();
        `CHK("LUT cascade", 10'h3ff, cell_q)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sync();
        t_gate();
        t_async();
        t_pair();
        t_edge();
        t_chain();
        t_arith();
        t_lut();
        give_verdict();
    end
endmodule // test_lcc_cluster
